// ### hdl/ltcd_decoder.sv
// line terminal command decoder: channel command bytes to terminal actions,
// plus serial sync hunt and width conversion for the input path
// assumes cmd_valid_i and the serial inputs arrive from pins or the far side
//
// Functional notes
// - channel unit is parity plus eight bits
// - convert narrower characters to channel units
// - never busy, every command examined
// - code 01 starts output sequence
// - code 05 needs dialing adapter
// - code 02 starts input, forwards characters
// - code 06 drops alignment, hunts syncs
// - hold input until first char other than sync or message begin
// - code 0A releases modem receive clock
// - code 03 ends sequence early
// - code 0B loops input to output
// - code 0F leaves test modes
// - code 13 drops terminal ready
// - code 07 puts modem in test
// - unacceptable command rejected and recorded
// - command parity error flagged
`timescale 1ns/1ps
`default_nettype none

module ltcd_decoder (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire ltcd_pkg::ltcd_cmd_type  cmd_i,
  input  wire logic                    cmd_valid_i,
  input  wire logic                    has_autocall_output_cmd_adapter_i,
  input  wire logic [3:0]              char_width_i,
  input  wire logic                    rx_serial_i,
  input  wire logic                    rx_bit_strobe_i,
  input  wire logic                    sense_clear_i,
  output logic                         cmd_ready_o,
  output ltcd_pkg::ltcd_evt_type       evt_o,
  output ltcd_pkg::ltcd_state_type     state_o,
  output ltcd_pkg::ltcd_unit_type      in_char_o,
  output logic                         in_char_valid_o,
  output logic                         cmd_reject_o,
  output logic                         bus_parity_chk_o
);
  import ltcd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers: valid, serial, strobe and sense clear pins pass two flops before any logic

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {cmd_valid_i, rx_serial_i, rx_bit_strobe_i, sense_clear_i};
      sync2_reg <= sync1_reg;
    end
  end

  wire cmd_lvl   = sync2_reg[3];
  wire rx_bit    = sync2_reg[2];
  wire rx_stb    = sync2_reg[1];
  wire sense_clr = sync2_reg[0];

  // command data registered every cycle, decoded when the synced valid rises; cmd_i needs no
  // sync of its own because the host holds it while valid is high
  ltcd_cmd_type cmd_reg;
  logic         cmd_lvl_d_reg;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_reg       <= '0;
      cmd_lvl_d_reg <= 1'b0;
    end else begin
      cmd_reg       <= cmd_i;
      cmd_lvl_d_reg <= cmd_lvl;
    end
  end
  wire cmd_take = cmd_lvl & ~cmd_lvl_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  // nine-bit unit, data bit 0 is the msb
  wire       par_ok  = ^{cmd_reg.unit.parity, cmd_reg.unit.data};
  wire [7:0] code    = cmd_reg.unit.data;
  wire       to_in   = cmd_reg.to_input;
  wire       sel     = cmd_reg.sel_phase;
  // output start, autocall only with adapter
  wire d_send  = ~to_in & sel & (code == CMD_SEND_DATA);
  wire d_auto  = ~to_in & sel & (code == CMD_AUTOCALL) & has_autocall_output_cmd_adapter_i;
  wire d_on    = to_in & sel & (code == CMD_TURN_ON);
  wire d_sync  = to_in & (code == CMD_RESYNC);
  wire d_nclk  = code == CMD_CLK_RELEASE;
  wire d_off   = code == CMD_TURN_OFF;
  wire d_loop  = to_in & (code == CMD_LOOPBACK);
  wire d_end   = to_in & (code == CMD_END_TEST);
  wire d_hang  = to_in & (code == CMD_HANGUP);
  wire d_mtest = to_in & (code == CMD_MODEM_TEST);
  wire d_any   = d_send | d_auto | d_on | d_sync | d_nclk | d_off
               | d_loop | d_end | d_hang | d_mtest;
  wire go      = cmd_take & par_ok;
  wire rej     = go & ~d_any;
  wire pchk    = cmd_take & ~par_ok;

  //////////////////////////////////////////////////////////////////////////////
  // sync hunt and character assembly on the input path

  typedef enum logic [1:0] {H_IDLE, H_SYNC1, H_SYNC2, H_HOLD} ltcd_hunt_type;
  ltcd_hunt_type hunt_reg, hunt_next;
  logic [7:0]    shift_reg;
  logic [3:0]    bitcnt_reg;
  wire  [7:0]    shift_next = {shift_reg[6:0], rx_bit};
  wire           sync_seen  = shift_next == SYNC_CHAR_RST;
  wire           hunting    = hunt_reg != H_IDLE;
  wire           char_done  = rx_stb & ~hunting & (bitcnt_reg + 4'h1 >= char_width_i);

  // hunt two syncs, skip optional message begin, hold until non-sync
  // a new resync drops whatever alignment or hunt was under way
  always_comb begin
    hunt_next = hunt_reg;
    if (go & d_sync) begin
      hunt_next = H_SYNC1;
    end else begin
      case (hunt_reg)
        H_IDLE:  hunt_next = H_IDLE;
        H_SYNC1: if (rx_stb & sync_seen) hunt_next = H_SYNC2;
        // second sync must follow the first directly, else search again
        H_SYNC2: if (rx_stb & (bitcnt_reg == 4'h7)) hunt_next = sync_seen ? H_HOLD : H_SYNC1;
        H_HOLD:  if (rx_stb & (bitcnt_reg == 4'h7)) begin
          if (!sync_seen && shift_next != MSG_BEGIN_RST) hunt_next = H_IDLE;
        end
        default: hunt_next = H_IDLE;
      endcase
    end
  end

  // bit counter restarts at each sync found, so the second sync is framed
  wire [3:0] bitcnt_next =
      (hunt_reg == H_SYNC1 && rx_stb && sync_seen) ? 4'h0 :
      (hunt_reg == H_SYNC2 && rx_stb && bitcnt_reg == 4'h7) ? 4'h0 :
      (hunt_reg == H_HOLD && rx_stb && bitcnt_reg == 4'h7) ? 4'h0 :
      char_done ? 4'h0 :
      rx_stb ? bitcnt_reg + 4'h1 : bitcnt_reg;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hunt_reg   <= H_IDLE;
      shift_reg  <= 8'h00;
      bitcnt_reg <= 4'h0;
    end else begin
      hunt_reg   <= hunt_next;
      shift_reg  <= rx_stb ? shift_next : shift_reg;
      bitcnt_reg <= bitcnt_next;
    end
  end

  // narrow character expanded to a channel unit, unused bits zero
  logic [7:0] mask;
  for (genvar gi = 0; gi < 8; gi++) begin : g_mask
    assign mask[gi] = char_width_i > 4'(gi);
  end
  wire [7:0] char_data = shift_next & mask;
  // the post-hunt first char other than sync or message begin is forwarded too
  wire       hold_pass = (hunt_reg == H_HOLD) & (hunt_next == H_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // terminal state and outputs

  ltcd_state_type st_reg, st_next;
  always_comb begin
    st_next = st_reg;
    st_next.hunting = hunt_next != H_IDLE;
    if (go) begin
      if (d_send | d_auto) st_next.out_active = 1'b1;
      if (d_on) st_next.in_active = 1'b1;
      if (d_off & to_in) st_next.in_active = 1'b0;
      if (d_off & ~to_in) st_next.out_active = 1'b0;
      if (d_nclk) st_next.rx_clk_release = 1'b1;
      if (d_loop) st_next.loopback = 1'b1;
      if (d_mtest) st_next.modem_test = 1'b1;
      if (d_end) begin
        st_next.loopback   = 1'b0;
        st_next.modem_test = 1'b0;
      end
      if (d_hang) st_next.dtr = 1'b0;
      // a new input start raises terminal ready again
      if (d_on) st_next.dtr = 1'b1;
    end
  end

  wire fwd = st_reg.in_active & (char_done | hold_pass);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg           <= '{default: 1'b0, dtr: 1'b1};
      evt_o            <= '0;
      in_char_o        <= '0;
      in_char_valid_o  <= 1'b0;
      cmd_ready_o      <= 1'b0;
      cmd_reject_o     <= 1'b0;
      bus_parity_chk_o <= 1'b0;
    end else begin
      st_reg           <= st_next;
      cmd_ready_o      <= 1'b1;
      evt_o            <= '{start_output: go & (d_send | d_auto),
                            start_input:  go & d_on,
                            resync:       go & d_sync,
                            early_stop:   go & d_off,
                            accept:       go & d_any,
                            reject:       rej,
                            parity_check: pchk};
      // forward assembled character with odd parity
      in_char_valid_o  <= fwd;
      in_char_o        <= '{parity: ~^char_data, data: char_data};
      cmd_reject_o     <= rej | (cmd_reject_o & ~sense_clr);
      bus_parity_chk_o <= pchk | (bus_parity_chk_o & ~sense_clr);
    end
  end

  assign state_o = st_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reject_sticky: assert property (rej |=> cmd_reject_o)
    else $error("reject not recorded");
  a_parity_flag: assert property (pchk |=> bus_parity_chk_o && !evt_o.accept)
    else $error("parity error not flagged");
  a_bad_par_quiet: assert property (cmd_take && !par_ok |=> evt_o == 7'h01 )
    else $error("bad parity byte acted");
  a_output_start: assert property (go && d_send |=> ##1 state_o.out_active)
    else $error("output not started");
  a_autocall_gate: assert property (
    go && !to_in && sel && code == CMD_AUTOCALL && !has_autocall_output_cmd_adapter_i |=> evt_o.reject)
    else $error("autocall accepted without adapter");
  a_input_start: assert property (go && d_on |=> ##1 state_o.in_active)
    else $error("input not started");
  a_hunt_start: assert property (go && d_sync |=> hunt_reg == H_SYNC1)
    else $error("hunt not entered");
  a_hunt_holds: assert property (hunting && hunt_next != H_IDLE |=> !in_char_valid_o)
    else $error("input during hunt");
  a_clk_release: assert property (go && d_nclk |=> ##1 state_o.rx_clk_release)
    else $error("clock not released");
  a_early_stop: assert property (go && d_off && to_in |=> ##1 !state_o.in_active)
    else $error("input not stopped");
  a_loop_on: assert property (go && d_loop && !d_end |=> ##1 state_o.loopback)
    else $error("loopback not set");
  a_end_test: assert property (go && d_end |=> ##1 !state_o.loopback && !state_o.modem_test)
    else $error("test not ended");
  a_hangup: assert property (go && d_hang |=> ##1 !state_o.dtr)
    else $error("ready not dropped");
  a_modem_test: assert property (go && d_mtest |=> ##1 state_o.modem_test)
    else $error("modem test not set");
  a_never_busy: assert property ($rose(cmd_ready_o) |=> cmd_ready_o [*4])
    else $error("decoder reported busy");
  a_unused_zero: assert property (in_char_valid_o |-> (in_char_o.data & ~mask) == 8'h00)
    else $error("unused bits not zero");

  // serial path, flag and event checks
  a_char_parity: assert property (in_char_valid_o |-> ^in_char_o)
    else $error("forwarded character parity even");
  a_sync_framed: assert property (
    hunt_reg == H_SYNC2 && rx_stb && bitcnt_reg == 4'h7 && !sync_seen |=> hunt_reg == H_SYNC1)
    else $error("second sync not adjacent");
  a_take_single: assert property (cmd_take |=> !cmd_take)
    else $error("one valid rise taken twice");
  a_flag_clear: assert property (sense_clr && !rej |=> !cmd_reject_o)
    else $error("reject flag not cleared");
  a_fwd_gated: assert property (!st_reg.in_active |=> !in_char_valid_o)
    else $error("character forwarded while input idle");
  a_acc_rej_excl: assert property (!(evt_o.accept && evt_o.reject))
    else $error("command accepted and rejected");
  a_dtr_restore: assert property (go && d_on |=> state_o.dtr)
    else $error("terminal ready not raised by input start");

  c_output_start: cover property (evt_o.start_output);
  c_resync_done:  cover property (hunt_reg == H_HOLD ##1 hunt_reg == H_IDLE);
  c_reject:       cover property (evt_o.reject);
  c_char_fwd:     cover property (in_char_valid_o);
  c_hangup:       cover property (go && d_hang);

endmodule

`default_nettype wire

// ### hdl/ltcd_pkg.sv
// package for the line terminal command decoder
// assumes one core clock; all consumers import ltcd_pkg::*
package ltcd_pkg;

  // command data fields, bit 0 of the byte is the msb
  localparam logic [7:0] CMD_SEND_DATA     = 8'h01;
  localparam logic [7:0] CMD_AUTOCALL      = 8'h05;
  localparam logic [7:0] CMD_TURN_ON       = 8'h02;
  localparam logic [7:0] CMD_RESYNC        = 8'h06;
  localparam logic [7:0] CMD_CLK_RELEASE   = 8'h0A;
  localparam logic [7:0] CMD_TURN_OFF      = 8'h03;
  localparam logic [7:0] CMD_LOOPBACK      = 8'h0B;
  localparam logic [7:0] CMD_END_TEST      = 8'h0F;
  localparam logic [7:0] CMD_HANGUP        = 8'h13;
  localparam logic [7:0] CMD_MODEM_TEST    = 8'h07;

  // default sync and message-begin characters
  localparam logic [7:0] SYNC_CHAR_RST     = 8'h16;
  localparam logic [7:0] MSG_BEGIN_RST     = 8'h01;
  localparam logic [3:0] CHAR_WIDTH_RST    = 4'h8;

  // one nine-bit channel unit: parity then data bits 0..7
  typedef struct packed {
    logic       parity;
    logic [7:0] data;
  } ltcd_unit_type;

  // command to decode with its target logic
  typedef struct packed {
    ltcd_unit_type unit;
    logic          to_input;   // odd address: input logic
    logic          sel_phase;  // presented in initial selection
  } ltcd_cmd_type;

  // decoded one-cycle actions
  typedef struct packed {
    logic start_output;
    logic start_input;
    logic resync;
    logic early_stop;
    logic accept;
    logic reject;
    logic parity_check;
  } ltcd_evt_type;

  // level state toward the terminal and interface
  typedef struct packed {
    logic out_active;
    logic in_active;
    logic hunting;
    logic rx_clk_release;
    logic loopback;
    logic modem_test;
    logic dtr;
  } ltcd_state_type;

endpackage

// ### tb/ltcd_host_model.sv
// host channel model: presents command units, gathers the decoder answer
// assumes the decoder answers within seven edges of a rising valid
`timescale 1ns/1ps
`default_nettype none

module ltcd_host_model (
  input  wire logic                   clk_i,
  input  wire ltcd_pkg::ltcd_evt_type evt_i,
  output ltcd_pkg::ltcd_cmd_type      cmd_o,
  output logic                        valid_o
);
  import ltcd_pkg::*;

  initial begin
    cmd_o = '0;
    valid_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one command; events are ored so a late pulse is still seen
  task automatic send(input logic [7:0] d, input logic ti, input logic sel,
                      input logic bad, output ltcd_evt_type seen);
    seen = '0;
    @(posedge clk_i);
    cmd_o <= '{'{(~^d) ^ bad, d}, ti, sel};
    valid_o <= 1'b1;
    repeat (7) begin
      @(posedge clk_i);
      #1 seen = seen | evt_i; // read once the edge has settled
    end
    valid_o <= 1'b0;
    repeat (3) @(posedge clk_i); // gap the decoder needs
  endtask
endmodule

`default_nettype wire

// ### tb/line_terminal_command_decoder_test.sv
// self-checking bench for the command decoder
// assumes one 200 MHz clock; host model drives the command side
`timescale 1ns/1ps
`default_nettype none

module line_terminal_command_decoder_test;
  import ltcd_pkg::*;
  logic           core_clk_i, rst_n_i, autocall_output_cmd, rx_ser, rx_stb, sclr, valid;
  ltcd_cmd_type   cmd;
  ltcd_evt_type   evt;
  ltcd_state_type st, st_exp;
  ltcd_unit_type  ch, last_ch;
  logic           ready, ch_vld, rej, par, rej_exp, par_exp;
  logic [31:0]    rnd;
  logic [3:0]     cw;
  int             error_cnt, check_count, n_ch, cyc;
  logic [7:0]     codes [9];

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  ltcd_host_model host_u (.clk_i(core_clk_i), .evt_i(evt), .cmd_o(cmd), .valid_o(valid));

  ltcd_decoder dut_u (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .cmd_valid_i(valid),
    .has_autocall_output_cmd_adapter_i(autocall_output_cmd), .char_width_i(cw), .rx_serial_i(rx_ser),
    .rx_bit_strobe_i(rx_stb), .sense_clear_i(sclr), .cmd_ready_o(ready), .evt_o(evt),
    .state_o(st), .in_char_o(ch), .in_char_valid_o(ch_vld), .cmd_reject_o(rej),
    .bus_parity_chk_o(par));

  ////////////////////////////////////////////////////////////////////////////
  // forwarded characters and hang guard, sampled mid-cycle
  always @(negedge core_clk_i) begin
    if (ch_vld === 1'b1) begin
      n_ch++;
      last_ch = ch;
    end
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // expected answer; updates the expected levels too
  function automatic ltcd_evt_type exp_evt(input logic [7:0] d, input logic ti,
      input logic sel, input logic dl, input logic bad, inout ltcd_state_type s);
    logic ok;
    exp_evt = '0;
    if (bad) begin
      exp_evt.parity_check = 1'b1; // bad byte does nothing else
      return exp_evt;
    end
    case (d)
      CMD_SEND_DATA: ok = !ti && sel;
      CMD_AUTOCALL: ok = !ti && sel && dl;
      CMD_TURN_ON: ok = ti && sel;
      CMD_CLK_RELEASE, CMD_TURN_OFF: ok = 1'b1;
      CMD_RESYNC, CMD_LOOPBACK, CMD_END_TEST, CMD_HANGUP, CMD_MODEM_TEST: ok = ti;
      default: ok = 1'b0;
    endcase
    exp_evt.accept = ok;
    exp_evt.reject = !ok;
    if (ok) begin
      case (d)
        CMD_SEND_DATA, CMD_AUTOCALL: {exp_evt.start_output, s.out_active} = 2'h3;
        CMD_TURN_ON: {exp_evt.start_input, s.in_active, s.dtr} = 3'h7;
        CMD_RESYNC: {exp_evt.resync, s.hunting} = 2'h3;
        CMD_CLK_RELEASE: s.rx_clk_release = 1'b1;
        CMD_TURN_OFF: begin
          exp_evt.early_stop = 1'b1;
          if (ti) s.in_active = 1'b0;
          else s.out_active = 1'b0;
        end
        CMD_LOOPBACK: s.loopback = 1'b1;
        CMD_END_TEST: {s.loopback, s.modem_test} = 2'h0;
        CMD_HANGUP: s.dtr = 1'b0;
        default: s.modem_test = 1'b1;
      endcase
    end
  endfunction

  task automatic do_cmd(input logic [7:0] d, input logic ti, input logic sel,
                        input logic dl, input logic bad);
    ltcd_evt_type seen, ex;
    autocall_output_cmd <= dl;
    ex = exp_evt(d, ti, sel, dl, bad, st_exp);
    rej_exp |= ex.reject;
    par_exp |= ex.parity_check;
    host_u.send(d, ti, sel, bad, seen);
    chk("evt", 10'(ex), 10'(seen));
    chk("state", 10'(st_exp), 10'(st));
    chk("flags", {8'h00, rej_exp, par_exp}, {8'h00, rej, par});
  endtask

  task automatic shift_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_ser <= b[i];
      @(posedge core_clk_i) rx_stb <= 1'b1;
      @(posedge core_clk_i) rx_stb <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: corners, serial hunt, then random traffic
  initial begin
    {rst_n_i, autocall_output_cmd, rx_ser, rx_stb, sclr, rej_exp, par_exp} = '0;
    {error_cnt, check_count, n_ch, cyc} = '0;
    cw = 4'h8;
    codes = '{CMD_SEND_DATA, CMD_AUTOCALL, CMD_TURN_ON, CMD_CLK_RELEASE, CMD_TURN_OFF,
              CMD_LOOPBACK, CMD_END_TEST, CMD_HANGUP, CMD_MODEM_TEST};
    st_exp = '0;
    st_exp.dtr = 1'b1;
    rnd = 32'h0001_3111;
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    chk("reset", {1'b1, 2'h0, 7'(st_exp)}, {ready, rej, par, 7'(st)});
    do_cmd(CMD_SEND_DATA, 1'b0, 1'b0, 1'b0, 1'b0);
    do_cmd(CMD_SEND_DATA, 1'b0, 1'b1, 1'b0, 1'b1);
    do_cmd(CMD_SEND_DATA, 1'b0, 1'b1, 1'b0, 1'b0);
    do_cmd(CMD_AUTOCALL, 1'b0, 1'b1, 1'b0, 1'b0);
    do_cmd(CMD_AUTOCALL, 1'b0, 1'b1, 1'b1, 1'b0);
    do_cmd(CMD_LOOPBACK, 1'b0, 1'b0, 1'b0, 1'b0);
    sclr <= 1'b1;
    repeat (4) @(posedge core_clk_i) sclr <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    {rej_exp, par_exp} = 2'h0;
    chk("cleared", 10'h000, {8'h00, rej, par});
    // sync hunt: two syncs, message begin skipped, next char forwarded
    do_cmd(CMD_TURN_ON, 1'b1, 1'b1, 1'b0, 1'b0);
    do_cmd(CMD_RESYNC, 1'b1, 1'b0, 1'b0, 1'b0);
    n_ch = 0;
    foreach (codes[i]) if (i < 4) shift_byte(i == 3 ? 8'hA5 : (i == 2 ? MSG_BEGIN_RST : SYNC_CHAR_RST));
    repeat (8) @(posedge core_clk_i);
    st_exp.hunting = 1'b0;
    chk("chars", 10'(1), 10'(n_ch));
    chk("char", {1'b0, ~^8'hA5, 8'hA5}, 10'(last_ch));
    chk("hunt", 10'(st_exp), 10'(st));
    // narrow width: five bits make a character, upper bits forced to zero
    cw <= 4'h5;
    shift_byte(8'hA8);
    repeat (8) @(posedge core_clk_i);
    chk("nchars", 10'(2), 10'(n_ch));
    chk("narrow", {1'b0, ~^8'h15, 8'h15}, 10'(last_ch));
    // random commands, some with bad parity or unknown code
    repeat (40) begin
      rnd = lfsr(rnd);
      do_cmd(rnd[7:4] > 4'h8 ? {3'h7, rnd[12:8]} : codes[rnd[7:4]], rnd[13], rnd[14],
             rnd[15], rnd[18:16] == 3'h0);
    end
    test_done();
  end
endmodule

`default_nettype wire
